/* File: design/pif_apb_slave.sv */
// APB slave front end: one wait-free access phase, registered answer
`timescale 1ns/10ps
module pif_apb_slave (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire pif_pkg::pif_apb_req_t         req,
  input  wire logic [pif_pkg::DATA_W-1:0]    rdata_mux,
  input  wire logic                          addr_err,
  output logic      [pif_pkg::DATA_W-1:0]    prdata,
  output logic                               pready,
  output logic                               pslverr,
  output logic                               setup_stb,
  output logic                               wr_stb,
  output logic                               rd_stb
);
  import pif_pkg::*;

  logic              pready_q;
  logic              pslverr_q;
  logic [DATA_W-1:0] prdata_q;
  logic              done;

  assign setup_stb = req.psel & ~req.penable & ~pready_q;
  assign done      = req.psel & req.penable & pready_q;
  // unmapped addresses are refused: no write, no read side effect
  assign wr_stb    = done & req.pwrite & ~pslverr_q;
  assign rd_stb    = done & ~req.pwrite & ~pslverr_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= setup_stb;
    end
  end

  // answer decided at setup so that pready and prdata leave flip-flops
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata_q  <= RST_WORD;
      pslverr_q <= 1'b0;
    end else if (setup_stb) begin
      prdata_q  <= req.pwrite ? RST_WORD : rdata_mux;
      pslverr_q <= addr_err;
    end else if (pready_q) begin
      // the answer stands exactly one cycle, whatever the master does next
      prdata_q  <= RST_WORD;
      pslverr_q <= 1'b0;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

endmodule

/* File: design/pif_flag_bank.sv */
// sticky flag bank: hardware set wins over software write and clear
`timescale 1ns/10ps
module pif_flag_bank #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] set_vec,
  input  wire logic [WIDTH-1:0] clr_vec,
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_data,
  output logic      [WIDTH-1:0] flags_q
);
  import pif_pkg::*;

  if (WIDTH < 1) begin : g_bad_width
    $error("pif_flag_bank: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] next_q;

  // one process owns the whole vector; an event in the clearing cycle is kept
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    assign next_q[i] = ((wr_en ? wr_data[i] : flags_q[i]) & ~clr_vec[i]) | set_vec[i];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      flags_q <= '0;
    end else begin
      flags_q <= next_q;
    end
  end

endmodule

/* File: design/pif_pkg.sv */
// constants, register map and carrier types of the peripheral interrupt flag/enable block
package pif_pkg;

  localparam int unsigned ADDR_W   = 12;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned BANK_W   = 8;

  // register byte offsets, one aligned word each
  localparam logic [ADDR_W-1:0] OFS_FLAGS2 = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_EN1    = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_EN2    = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 12'h00C;
  localparam logic [ADDR_W-1:0] OFS_FLAGS1 = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_STAT   = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_MASK   = 12'h018;

  // second flag bank bit positions
  localparam int unsigned BIT_OSC_FAIL    = 7;
  localparam int unsigned BIT_CMP_CHANGE  = 6;
  localparam int unsigned BIT_USB_REQ     = 5;
  localparam int unsigned BIT_NV_DONE     = 4;
  localparam int unsigned BIT_BUS_COLL    = 3;
  localparam int unsigned BIT_VOLT_DET    = 2;
  localparam int unsigned BIT_TIMER_THREE_OVF    = 1;
  localparam int unsigned BIT_CAPCOMP2    = 0;

  // control register bits
  localparam int unsigned CTRL_PGE_BIT    = 6;
  localparam int unsigned CTRL_PRIORITY_MODE_ENABLE_BIT   = 7;

  localparam logic [BANK_W-1:0] RST_BANK  = 8'h00;
  localparam logic [DATA_W-1:0] RST_WORD  = 32'h0000_0000;

  // capture/compare unit 2 operating mode, one-hot
  typedef enum logic [2:0] {
    PIF_CCP_CAPTURE = 3'b001,
    PIF_CCP_COMPARE = 3'b010,
    PIF_CCP_PWM     = 3'b100
  } pif_ccp_mode_t;

  // one-cycle event pulses from the peripherals
  typedef struct packed {
    logic osc_fail;
    logic comparator_change;
    logic usb_request;
    logic nv_write_done;
    logic bus_collision;
    logic voltage_detect;
    logic timer3_overflow;
    logic capcomp2_capture;
    logic capcomp2_compare;
  } pif_events_t;

  typedef struct packed {
    logic [ADDR_W-1:0] paddr;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [DATA_W-1:0] pwdata;
  } pif_apb_req_t;

endpackage

/* File: design/pif_top.sv */
// peripheral interrupt flags (second bank), enables and request gating
`timescale 1ns/10ps

// Functional notes
// - oscillator fail sets bit 7, sticky until software clears it
// - comparator change sets bit 6, sticky until software writes zero
// - USB engine request sets bit 5, sticky until software clears it
// - nonvolatile write finish sets bit 4; zero otherwise; software clears
// - serial bus collision sets bit 3, sticky until software clears it
// - voltage detector trip sets bit 2, sticky until software clears it
// - timer three overflow sets bit 1, sticky until software clears it
// - capture mode: timer capture sets bit 0; software clears
// - compare mode: compare match sets bit 0; pulse-width mode never sets
// - priority mode off: no peripheral request passes without global enable
// - two enable registers, one bit per source masking its flag
// - second flag register is 8 bits, read/write, reset to zero
// - first enable register: eight read/write enables, reset zero, fixed order
// - flags set on events regardless of any enable, allowing polling
// - priority mode on: same enable bit acts as low-priority global enable
module pif_top (
  input  wire logic                          ref_clk,
  input  wire logic                          sys_rst,
  input  wire pif_pkg::pif_apb_req_t         apb_req,
  output logic      [pif_pkg::DATA_W-1:0]    prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire pif_pkg::pif_events_t          events,
  input  wire pif_pkg::pif_ccp_mode_t        capcomp2_mode,
  input  wire logic [pif_pkg::BANK_W-1:0]    flags1_in,
  output logic                               peripheral_irq,
  output logic                               low_priority_irq,
  output logic                               irq
);
  import pif_pkg::*;

  // elaboration checks: every field must fit the bank and the bus word
  if (BANK_W > DATA_W) begin : g_bad_bank_w
    $error("pif_top: BANK_W must not exceed DATA_W");
  end
  if ((BIT_OSC_FAIL >= BANK_W) || (BIT_CMP_CHANGE >= BANK_W) ||
      (BIT_USB_REQ >= BANK_W) || (BIT_NV_DONE >= BANK_W) ||
      (BIT_BUS_COLL >= BANK_W) || (BIT_VOLT_DET >= BANK_W) ||
      (BIT_TIMER_THREE_OVF >= BANK_W) || (BIT_CAPCOMP2 >= BANK_W)) begin : g_bad_flag_bit
    $error("pif_top: a flag bit lies outside the bank");
  end
  if ((CTRL_PGE_BIT >= BANK_W) || (CTRL_PRIORITY_MODE_ENABLE_BIT >= BANK_W) ||
      (CTRL_PGE_BIT == CTRL_PRIORITY_MODE_ENABLE_BIT)) begin : g_bad_ctrl_bit
    $error("pif_top: control bits must be distinct and inside the low byte");
  end
  // word aligned and strictly rising offsets keep every decode unique
  if ((OFS_FLAGS2[1:0] != 2'h0) || (OFS_EN1[1:0] != 2'h0) ||
      (OFS_EN2[1:0] != 2'h0) || (OFS_CTRL[1:0] != 2'h0) ||
      (OFS_FLAGS1[1:0] != 2'h0) || (OFS_STAT[1:0] != 2'h0) ||
      (OFS_MASK[1:0] != 2'h0)) begin : g_bad_align
    $error("pif_top: register offsets must be word aligned");
  end
  if ((OFS_FLAGS2 >= OFS_EN1) || (OFS_EN1 >= OFS_EN2) ||
      (OFS_EN2 >= OFS_CTRL) || (OFS_CTRL >= OFS_FLAGS1) ||
      (OFS_FLAGS1 >= OFS_STAT) || (OFS_STAT >= OFS_MASK)) begin : g_bad_order
    $error("pif_top: register offsets must rise strictly");
  end

  logic [BANK_W-1:0] flags2_q;
  logic [BANK_W-1:0] en1_q;
  logic [BANK_W-1:0] en2_q;
  logic              pge_q;
  logic              priority_mode_enable_q;
  logic [BANK_W-1:0] stat_q;
  logic [BANK_W-1:0] mask_q;
  logic [BANK_W-1:0] stat_snap_q;
  logic              periph_irq_q;
  logic              low_irq_q;
  logic              irq_q;

  logic [BANK_W-1:0] set2;
  logic [DATA_W-1:0] rdata_mux;
  logic              addr_err;
  logic              setup_stb;
  logic              wr_stb;
  logic              rd_stb;
  logic [BANK_W-1:0] wbyte;
  logic              hit_flags2;
  logic              hit_en1;
  logic              hit_en2;
  logic              hit_ctrl;
  logic              hit_flags1;
  logic              hit_stat;
  logic              hit_mask;
  logic              cap_set;
  logic              cmp_set;
  logic              any_req;
  logic              mode_capture;
  logic              mode_compare;
  logic              wr_flags2;
  logic              wr_en1;
  logic              wr_en2;
  logic              wr_ctrl;
  logic              wr_mask;
  logic              rd_stat;
  logic [BANK_W-1:0] stat_clr;
  logic [BANK_W-1:0] ctrl_view;
  logic [BANK_W-1:0] req1;
  logic [BANK_W-1:0] req2;
  logic [BANK_W-1:0] stat_req;

  // register bus
  pif_apb_slave u_apb (
    .clk       (ref_clk),
    .rst       (sys_rst),
    .req       (apb_req),
    .rdata_mux (rdata_mux),
    .addr_err  (addr_err),
    .prdata    (prdata),
    .pready    (pready),
    .pslverr   (pslverr),
    .setup_stb (setup_stb),
    .wr_stb    (wr_stb),
    .rd_stb    (rd_stb)
  );

  assign wbyte      = apb_req.pwdata[BANK_W-1:0];
  assign hit_flags2 = (apb_req.paddr == OFS_FLAGS2);
  assign hit_en1    = (apb_req.paddr == OFS_EN1);
  assign hit_en2    = (apb_req.paddr == OFS_EN2);
  assign hit_ctrl   = (apb_req.paddr == OFS_CTRL);
  assign hit_flags1 = (apb_req.paddr == OFS_FLAGS1);
  assign hit_stat   = (apb_req.paddr == OFS_STAT);
  assign hit_mask   = (apb_req.paddr == OFS_MASK);

  // completed accesses per register; a refused access reaches none of these
  assign wr_flags2 = wr_stb & hit_flags2;
  assign wr_en1    = wr_stb & hit_en1;
  assign wr_en2    = wr_stb & hit_en2;
  assign wr_ctrl   = wr_stb & hit_ctrl;
  assign wr_mask   = wr_stb & hit_mask;
  assign rd_stat   = rd_stb & hit_stat;
  // only the bits shown to the reader are cleared
  assign stat_clr  = rd_stat ? stat_snap_q : RST_BANK;

  // control word as read back; its other bits are unused and read zero
  always_comb begin
    ctrl_view                = RST_BANK;
    ctrl_view[CTRL_PGE_BIT]  = pge_q;
    ctrl_view[CTRL_PRIORITY_MODE_ENABLE_BIT] = priority_mode_enable_q;
  end

  // read mux and decode; narrow registers sit in the low byte
  always_comb begin
    rdata_mux = RST_WORD;
    addr_err  = 1'b0;
    if (hit_flags2) begin
      rdata_mux[BANK_W-1:0] = flags2_q;
    end else if (hit_en1) begin
      rdata_mux[BANK_W-1:0] = en1_q;
    end else if (hit_en2) begin
      rdata_mux[BANK_W-1:0] = en2_q;
    end else if (hit_ctrl) begin
      rdata_mux[BANK_W-1:0] = ctrl_view;
    end else if (hit_flags1) begin
      rdata_mux[BANK_W-1:0] = flags1_in;
    end else if (hit_stat) begin
      rdata_mux[BANK_W-1:0] = stat_q;
    end else if (hit_mask) begin
      rdata_mux[BANK_W-1:0] = mask_q;
    end else begin
      addr_err = 1'b1;
    end
  end

  // capture/compare unit 2: the mode decides which event counts
  assign mode_capture = (capcomp2_mode == PIF_CCP_CAPTURE);
  assign mode_compare = (capcomp2_mode == PIF_CCP_COMPARE);
  // pulse-width mode matches neither, so the unit never sets its flag there
  assign cap_set = events.capcomp2_capture & mode_capture;
  assign cmp_set = events.capcomp2_compare & mode_compare;

  // set vector of the second flag bank, independent of every enable
  always_comb begin
    set2                 = RST_BANK;
    set2[BIT_OSC_FAIL]   = events.osc_fail;
    set2[BIT_CMP_CHANGE] = events.comparator_change;
    set2[BIT_USB_REQ]    = events.usb_request;
    set2[BIT_NV_DONE]    = events.nv_write_done;
    set2[BIT_BUS_COLL]   = events.bus_collision;
    set2[BIT_VOLT_DET]   = events.voltage_detect;
    set2[BIT_TIMER_THREE_OVF]   = events.timer3_overflow;
    set2[BIT_CAPCOMP2]   = cap_set | cmp_set;
  end

  // software writes any value; writing zero is the documented clear
  pif_flag_bank #(
    .WIDTH (BANK_W)
  ) u_flags2 (
    .clk     (ref_clk),
    .rst     (sys_rst),
    .set_vec (set2),
    .clr_vec (RST_BANK),
    .wr_en   (wr_flags2),
    .wr_data (wbyte),
    .flags_q (flags2_q)
  );

  // event status: only the bits shown to the reader are cleared, so an
  // event that lands between setup and completion survives the read
  pif_flag_bank #(
    .WIDTH (BANK_W)
  ) u_stat (
    .clk     (ref_clk),
    .rst     (sys_rst),
    .set_vec (set2),
    .clr_vec (stat_clr),
    .wr_en   (1'b0),
    .wr_data (RST_BANK),
    .flags_q (stat_q)
  );

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      stat_snap_q <= RST_BANK;
    end else if (setup_stb) begin
      stat_snap_q <= stat_q;
    end
  end

  // enable banks; the second mirrors the layout of the second flag bank
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      en1_q <= RST_BANK;
    end else if (wr_en1) begin
      en1_q <= wbyte;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      en2_q <= RST_BANK;
    end else if (wr_en2) begin
      en2_q <= wbyte;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pge_q <= 1'b0;
    end else if (wr_ctrl) begin
      pge_q <= apb_req.pwdata[CTRL_PGE_BIT];
    end
  end

  // priority mode picks which request output the sources drive
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      priority_mode_enable_q <= 1'b0;
    end else if (wr_ctrl) begin
      priority_mode_enable_q <= apb_req.pwdata[CTRL_PRIORITY_MODE_ENABLE_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mask_q <= RST_BANK;
    end else if (wr_mask) begin
      mask_q <= wbyte;
    end
  end

  // per-source masking of both flag banks and of the event status
  for (genvar i = 0; i < BANK_W; i++) begin : g_req
    assign req1[i]     = flags1_in[i] & en1_q[i];
    assign req2[i]     = flags2_q[i] & en2_q[i];
    assign stat_req[i] = stat_q[i] & mask_q[i];
  end
  assign any_req = (|req1) | (|req2);

  // priority registers live elsewhere, so in priority mode every source here
  // is treated as low priority and the same enable bit gates it
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      periph_irq_q <= 1'b0;
    end else begin
      periph_irq_q <= any_req & pge_q & ~priority_mode_enable_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      low_irq_q <= 1'b0;
    end else begin
      low_irq_q <= any_req & pge_q & priority_mode_enable_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |stat_req;
    end
  end

  assign peripheral_irq   = periph_irq_q;
  assign low_priority_irq = low_irq_q;
  assign irq              = irq_q;

endmodule

/* File: tb/pif_event_src.sv */
// peripheral event sources: each request leaves one cycle later, as many cycles long as fire was held
`timescale 1ns/10ps
module pif_event_src (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire pif_pkg::pif_events_t fire,
  output pif_pkg::pif_events_t      events
);
  import pif_pkg::*;
  // registered so pulses change only just after an edge
  always_ff @(posedge clk) begin
    events <= rst ? '0 : fire;
  end
endmodule

/* File: tb/pif_monitor.sv */
// port-level checks of the peripheral interrupt flag block
`timescale 1ns/10ps
module pif_monitor (
  input wire logic                       ref_clk,
  input wire logic                       sys_rst,
  input wire pif_pkg::pif_apb_req_t      apb_req,
  input wire logic [pif_pkg::DATA_W-1:0] prdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  input wire logic                       peripheral_irq,
  input wire logic                       low_priority_irq
);
  import pif_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence setup_s; apb_req.psel && !apb_req.penable && !pready; endsequence
  sequence access_s; apb_req.psel && apb_req.penable && pready; endsequence
  wire logic unmapped = !(apb_req.paddr inside {OFS_FLAGS2, OFS_EN1, OFS_EN2, OFS_CTRL,
                                                OFS_FLAGS1, OFS_STAT, OFS_MASK});
  answer_next_a: assert property (setup_s |=> access_s)
    else $error("no answer one cycle after setup");
  ready_once_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  ready_cause_a: assert property (pready |-> $past(apb_req.psel && !apb_req.penable))
    else $error("ready without setup");
  err_map_a: assert property (pready |-> pslverr == unmapped)
    else $error("error flag wrong for address");
  err_alone_a: assert property (pslverr |-> pready && prdata == '0)
    else $error("error without ready or with data");
  idle_data_a: assert property (!pready |-> prdata == '0)
    else $error("read data outside access");
  write_data_a: assert property (pready && apb_req.pwrite |-> prdata == '0)
    else $error("read data on write");
  irq_split_a: assert property (!(peripheral_irq && low_priority_irq))
    else $error("both request outputs high");
endmodule
bind pif_top pif_monitor i_pif_monitor (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .peripheral_irq(peripheral_irq), .low_priority_irq(low_priority_irq));

/* File: tb/pif_top_bench.sv */
// self-checking bench for the peripheral interrupt flag block
`timescale 1ns/10ps
module pif_top_bench;
  import pif_pkg::*;
  logic          ref_clk = 1'b0;
  logic          sys_rst = 1'b1;
  pif_apb_req_t  apb_req = '0;
  pif_events_t   fire = '0;
  pif_events_t   events;
  pif_ccp_mode_t capcomp2_mode = PIF_CCP_CAPTURE;
  logic [7:0]    flags1_in = 8'h00;
  logic [31:0]   prdata;
  logic [31:0]   q;
  logic          pready, pslverr, peripheral_irq, low_priority_irq, irq, e;
  int            err_total = 0;
  int            comparisons = 0;
  pif_ccp_mode_t md[4] = '{PIF_CCP_COMPARE, PIF_CCP_COMPARE, PIF_CCP_PWM, PIF_CCP_CAPTURE};
  logic [8:0]    ev[4] = '{9'h001, 9'h002, 9'h003, 9'h001};

  always #2 ref_clk = ~ref_clk;

  pif_top i_pif_top (.ref_clk(ref_clk), .sys_rst(sys_rst), .apb_req(apb_req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .events(events),
    .capcomp2_mode(capcomp2_mode), .flags1_in(flags1_in), .peripheral_irq(peripheral_irq),
    .low_priority_irq(low_priority_irq), .irq(irq));
  pif_event_src i_pif_event_src (.clk(ref_clk), .rst(sys_rst), .fire(fire), .events(events));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // request held until ready is seen high at an edge; an edge passes first so
  // a release and the next setup never land in one time step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    apb_req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge ref_clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    apb_req <= '{paddr: a, psel: 1'b0, penable: 1'b0, pwrite: w, pwdata: d};
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(q, exp);
  endtask
  task automatic pulse(input logic [8:0] v);
    fire <= pif_events_t'(v);
    @(posedge ref_clk);
    fire <= '0;
    repeat (2) @(posedge ref_clk);
  endtask
  // expected order: peripheral, low priority, status
  task automatic irqs(input logic [2:0] exp);
    repeat (3) @(posedge ref_clk);
    chk({29'h0, peripheral_irq, low_priority_irq, irq}, {29'h0, exp});
  endtask
  task automatic summarize();
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    for (int i = 0; i < 7; i++) rd(12'(i * 4), 32'h0000_0000);
    $display("reset values done");
    for (int b = 0; b < 8; b++) begin
      pulse(9'h002 << b);
      rd(OFS_FLAGS2, 32'(8'h01 << b));
      apb(1'b1, OFS_FLAGS2, 32'h0000_0000);
      rd(OFS_FLAGS2, 32'h0000_0000);
    end
    $display("flag events done");
    for (int i = 0; i < 4; i++) begin
      capcomp2_mode <= md[i];
      pulse(ev[i]);
      rd(OFS_FLAGS2, {31'h0, i == 0});
      apb(1'b1, OFS_FLAGS2, 32'h0000_0000);
    end
    $display("capture modes done");
    apb(1'b1, OFS_EN1, 32'h0000_00A5);
    rd(OFS_EN1, 32'h0000_00A5);
    flags1_in <= 8'h04;
    irqs(3'b000);
    apb(1'b1, OFS_CTRL, 32'h0000_0040);
    irqs(3'b100);
    apb(1'b1, OFS_EN1, 32'h0000_00A1);
    irqs(3'b000);
    apb(1'b1, OFS_CTRL, 32'h0000_00C0);
    apb(1'b1, OFS_EN1, 32'h0000_00A5);
    irqs(3'b010);
    rd(OFS_FLAGS1, 32'h0000_0004);
    apb(1'b1, OFS_EN1, 32'h0000_0000);
    apb(1'b1, OFS_FLAGS2, 32'h0000_0010);
    apb(1'b1, OFS_EN2, 32'h0000_0010);
    irqs(3'b010);
    apb(1'b1, OFS_CTRL, 32'h0000_0000);
    irqs(3'b000);
    $display("gating done");
    apb(1'b0, OFS_STAT, 32'h0000_0000);
    pulse(9'h100);
    irqs(3'b000);
    rd(OFS_STAT, 32'h0000_0080);
    rd(OFS_STAT, 32'h0000_0000);
    apb(1'b1, OFS_MASK, 32'h0000_0080);
    pulse(9'h100);
    irqs(3'b001);
    rd(OFS_STAT, 32'h0000_0080);
    irqs(3'b000);
    rd(12'h01C, 32'h0000_0000);
    chk({31'h0, e}, 32'h0000_0001);
    $display("interrupts and unmapped done");
    summarize();
  end

  initial begin
    #20000;
    err_total++;
    summarize();
  end
endmodule
